//--- rtl/msch_scheduler.sv
`timescale 1ns/100ps
`include "msch_map.svh"
module msch_scheduler #(
  parameter int TICK_CYCLES = `MSCH_TICK_CYCLES,
  parameter int TEMP_CONV_MS = 1
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic start_wr,
  input wire logic start_wdata,
  output logic start_bit,
  output logic meas_busy,
  output logic pres_done,
  output logic temp_done,
  output logic [7:0] avg_samples
);
  // ****************************
  // state
  // ****************************
  typedef struct packed {
    logic [7:0] measurement_config;
    logic [7:0] standby_config;
    logic [7:0] avg_cfg;
    logic start;
    msch_pkg::msch_state_t fsm;
    logic is_temp;
    logic first_pres;
    logic temp_seen;
    logic [8:0] pres_cnt;
    logic [19:0] ms_left;
    logic [7:0] samp_left;
    logic pres_done;
    logic temp_done;
    logic [7:0] avg_samples;
    logic [7:0] rdata;
  } msch_st_t;

  msch_st_t st_ff;
  msch_st_t nxt_st;
  msch_pkg::msch_cfg_t cfg;
  logic ms_tick;

  // ****************************
  // lookup functions
  // ****************************
  function automatic logic [8:0] ratio_count(input logic [2:0] code);
    ratio_count = (code == 3'h0) ? 9'h001 : 9'(9'h002 << code);
  endfunction : ratio_count

  function automatic logic [7:0] avg_count(input logic [2:0] code);
    avg_count = 8'(8'h01 << code);
  endfunction : avg_count

  function automatic logic [19:0] conv_ms(input logic [1:0] code, input logic first);
    logic [19:0] base;
    base = 20'(20'h00001 << code);
    conv_ms = first ? 20'(base << 2) : base;
  endfunction : conv_ms

  function automatic logic [19:0] stby_ms(input logic [3:0] code);
    unique case (code)
      4'h2: stby_ms = 20'h0000A;
      4'h3: stby_ms = 20'h00014;
      4'h4: stby_ms = 20'h0001E;
      4'h5: stby_ms = 20'h00032;
      4'h6: stby_ms = 20'h00064;
      4'h7: stby_ms = 20'h000FA;
      4'h8: stby_ms = 20'h001F4;
      4'h9: stby_ms = 20'h002EE;
      4'hA: stby_ms = 20'h003E8;
      4'hB: stby_ms = 20'h007D0;
      4'hC: stby_ms = 20'h01388;
      4'hD: stby_ms = 20'h02710;
      4'hE: stby_ms = 20'h0EA60;
      4'hF: stby_ms = 20'h927C0;
      default: stby_ms = 20'h00000;
    endcase
  endfunction : stby_ms

  always_comb begin
    cfg.conv_time = st_ff.measurement_config[`MSCH_CONV_MSB:`MSCH_CONV_LSB];
    cfg.ratio = st_ff.measurement_config[`MSCH_RATIO_MSB:`MSCH_RATIO_LSB];
    cfg.standby = st_ff.standby_config[`MSCH_STBY_MSB:`MSCH_STBY_LSB];
    cfg.pavg = st_ff.avg_cfg[`MSCH_PAVG_MSB:`MSCH_PAVG_LSB];
    cfg.tavg = st_ff.avg_cfg[`MSCH_TAVG_MSB:`MSCH_TAVG_LSB];
    cfg.temp_sel = start_sel_t();
    cfg.pres_sel = start_sel_p();
  end

  // selections live in the mode register outside this block; tied on here
  function automatic logic start_sel_t();
    start_sel_t = 1'b1;
  endfunction : start_sel_t

  function automatic logic start_sel_p();
    start_sel_p = 1'b1;
  endfunction : start_sel_p

  msch_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clock(clock),
    .srst(srst),
    .run(st_ff.fsm != msch_pkg::MSCH_IDLE),
    .ms_tick(ms_tick)
  );

  // ****************************
  // next state
  // ****************************
  always_comb begin
    logic next_temp;
    next_temp = 1'b0;
    nxt_st = st_ff;
    nxt_st.pres_done = 1'b0;
    nxt_st.temp_done = 1'b0;
    if (reg_wr) begin
      unique case (reg_addr)
        `MSCH_ADDR_MEASUREMENT_CONFIG: nxt_st.measurement_config = reg_wdata;
        `MSCH_ADDR_STANDBY_CONFIG: nxt_st.standby_config = reg_wdata;
        `MSCH_ADDR_AVG_CFG: nxt_st.avg_cfg = reg_wdata;
        default: ;
      endcase
    end
    if (start_wr) begin
      nxt_st.start = start_wdata;
    end
    unique case (reg_addr)
      `MSCH_ADDR_MEASUREMENT_CONFIG: nxt_st.rdata = st_ff.measurement_config;
      `MSCH_ADDR_STANDBY_CONFIG: nxt_st.rdata = st_ff.standby_config;
      `MSCH_ADDR_AVG_CFG: nxt_st.rdata = st_ff.avg_cfg;
      default: nxt_st.rdata = 8'h00;
    endcase
    // temperature due first, then after each ratio count of pressures
    if (cfg.temp_sel && !cfg.pres_sel) begin
      next_temp = 1'b1;
    end else if (!cfg.temp_sel && cfg.pres_sel) begin
      next_temp = !st_ff.temp_seen;
    end else begin
      next_temp = !st_ff.temp_seen || (st_ff.pres_cnt >= ratio_count(cfg.ratio));
    end
    unique case (st_ff.fsm)
      msch_pkg::MSCH_IDLE: begin
        nxt_st.temp_seen = 1'b0;
        nxt_st.first_pres = 1'b1;
        nxt_st.pres_cnt = 9'h000;
        if (st_ff.start && (cfg.temp_sel || cfg.pres_sel)) begin
          nxt_st.fsm = msch_pkg::MSCH_CONV;
          nxt_st.is_temp = 1'b1;
          nxt_st.samp_left = avg_count(cfg.tavg);
          nxt_st.ms_left = 20'(TEMP_CONV_MS);
        end
      end
      msch_pkg::MSCH_CONV: begin
        if (ms_tick) begin
          if (st_ff.ms_left > 20'h00001) begin
            nxt_st.ms_left = st_ff.ms_left - 20'h00001;
          end else if (st_ff.samp_left > 8'h01) begin
            // averaging: repeat conversions until all samples taken
            nxt_st.samp_left = st_ff.samp_left - 8'h01;
            nxt_st.ms_left = st_ff.is_temp ? 20'(TEMP_CONV_MS) : conv_ms(cfg.conv_time, 1'b0);
          end else begin
            nxt_st.avg_samples = st_ff.is_temp ? avg_count(cfg.tavg) : avg_count(cfg.pavg);
            if (st_ff.is_temp) begin
              nxt_st.temp_done = 1'b1;
              nxt_st.temp_seen = 1'b1;
              nxt_st.pres_cnt = 9'h000;
            end else begin
              nxt_st.pres_done = 1'b1;
              nxt_st.first_pres = 1'b0;
              nxt_st.pres_cnt = st_ff.pres_cnt + 9'h001;
            end
            if (cfg.standby == 4'h1) begin
              nxt_st.fsm = msch_pkg::MSCH_DONE;
            end else if (cfg.standby == 4'h0) begin
              nxt_st.fsm = msch_pkg::MSCH_STBY;
              nxt_st.ms_left = 20'h00000;
            end else begin
              nxt_st.fsm = msch_pkg::MSCH_STBY;
              nxt_st.ms_left = stby_ms(cfg.standby);
            end
          end
        end
      end
      msch_pkg::MSCH_STBY: begin
        if (st_ff.ms_left == 20'h00000 || (ms_tick && st_ff.ms_left == 20'h00001)) begin
          nxt_st.fsm = msch_pkg::MSCH_CONV;
          nxt_st.is_temp = next_temp;
          nxt_st.samp_left = next_temp ? avg_count(cfg.tavg) : avg_count(cfg.pavg);
          nxt_st.ms_left = next_temp ? 20'(TEMP_CONV_MS) : conv_ms(cfg.conv_time, st_ff.first_pres);
        end else if (ms_tick) begin
          nxt_st.ms_left = st_ff.ms_left - 20'h00001;
        end
      end
      msch_pkg::MSCH_DONE: begin
        // a host write of start in this same cycle wins over the automatic clear
        if (!start_wr) begin
          nxt_st.start = 1'b0;
        end
        nxt_st.fsm = msch_pkg::MSCH_IDLE;
      end
      default: nxt_st.fsm = msch_pkg::MSCH_IDLE;
    endcase
    if (!nxt_st.start) begin
      nxt_st.fsm = msch_pkg::MSCH_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_ff <= '0;
      st_ff.measurement_config <= `MSCH_RST_MEASUREMENT_CONFIG;
      st_ff.standby_config <= `MSCH_RST_STANDBY_CONFIG;
      st_ff.avg_cfg <= `MSCH_RST_AVG_CFG;
      st_ff.fsm <= msch_pkg::MSCH_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata;
  assign start_bit = st_ff.start;
  assign meas_busy = (st_ff.fsm != msch_pkg::MSCH_IDLE);
  assign pres_done = st_ff.pres_done;
  assign temp_done = st_ff.temp_done;
  assign avg_samples = st_ff.avg_samples;
endmodule : msch_scheduler

//--- rtl/msch_map.svh
`ifndef MSCH_MAP_SVH
`define MSCH_MAP_SVH
`define MSCH_ADDR_MEASUREMENT_CONFIG 8'h07
`define MSCH_ADDR_STANDBY_CONFIG 8'h08
`define MSCH_ADDR_AVG_CFG 8'h09
`define MSCH_RST_MEASUREMENT_CONFIG 8'h08
`define MSCH_RST_STANDBY_CONFIG 8'h00
`define MSCH_RST_AVG_CFG 8'h00
`define MSCH_CONV_LSB 3
`define MSCH_CONV_MSB 4
`define MSCH_RATIO_LSB 0
`define MSCH_RATIO_MSB 2
`define MSCH_STBY_LSB 0
`define MSCH_STBY_MSB 3
`define MSCH_PAVG_LSB 3
`define MSCH_PAVG_MSB 5
`define MSCH_TAVG_LSB 0
`define MSCH_TAVG_MSB 2
`define MSCH_CLK_KHZ 250000
`define MSCH_CONV_BASE_MS 1
`define MSCH_TICK_CYCLES (`MSCH_CLK_KHZ)
`endif

//--- rtl/msch_pkg.sv
package msch_pkg;
  typedef enum logic [3:0] {
    MSCH_IDLE = 4'h1,
    MSCH_CONV = 4'h2,
    MSCH_STBY = 4'h4,
    MSCH_DONE = 4'h8
  } msch_state_t;

  typedef struct packed {
    logic [1:0] conv_time;
    logic [2:0] ratio;
    logic [3:0] standby;
    logic [2:0] pavg;
    logic [2:0] tavg;
    logic temp_sel;
    logic pres_sel;
  } msch_cfg_t;

  typedef struct packed {
    logic pres_done;
    logic temp_done;
    logic [7:0] avg_count;
    logic busy;
  } msch_evt_t;
endpackage : msch_pkg

//--- rtl/msch_tick.sv
`timescale 1ns/100ps
`include "msch_map.svh"
// ****************************
// millisecond enable divider
// ****************************
module msch_tick #(
  parameter int TICK_CYCLES = `MSCH_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic run,
  output logic ms_tick
);
  typedef struct packed {
    logic [17:0] cnt;
    logic tick;
  } msch_tick_st_t;

  msch_tick_st_t st_ff;
  msch_tick_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (!run) begin
      nxt_st.cnt = 18'h00000;
    end else if (st_ff.cnt == 18'(TICK_CYCLES - 1)) begin
      nxt_st.cnt = 18'h00000;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 18'h00001;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign ms_tick = st_ff.tick;
endmodule : msch_tick

//--- verification/msch_checker.sv
`timescale 1ns/100ps
// ****************************
// scheduler port checks
// ****************************
module msch_checker (
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic start_wr,
  input wire logic start_wdata,
  input wire logic start_bit,
  input wire logic meas_busy,
  input wire logic pres_done,
  input wire logic temp_done,
  input wire logic [7:0] avg_samples
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  logic [7:0] stby_ff;
  logic [7:0] avg_ff;
  logic seen_ff;
  // shadow copies so results can be tied to the programmed fields
  always_ff @(posedge clock) begin
    if (srst) begin
      stby_ff <= 8'h00;
      avg_ff <= 8'h00;
      seen_ff <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 8'h08) stby_ff <= reg_wdata;
      if (reg_wr && reg_addr == 8'h09) avg_ff <= reg_wdata;
      if (start_wr && start_wdata) seen_ff <= 1'b0;
      else if (temp_done) seen_ff <= 1'b1;
    end
  end
  a_unmapped_reads_zero: assert property (!(reg_addr inside {8'h07, 8'h08, 8'h09}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_standby_readback: assert property (reg_wr && reg_addr == 8'h08 ##1 reg_addr == 8'h08
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("standby readback wrong");
  a_start_gives_busy: assert property (start_wr && start_wdata && !meas_busy |-> ##[1:2] meas_busy)
    else $error("start did not run engine");
  a_stop_gives_idle: assert property (start_wr && !start_wdata |-> ##[1:3] (!meas_busy && !start_bit))
    else $error("stop did not idle engine");
  a_done_one_cycle: assert property ((pres_done || temp_done) |=> !pres_done && !temp_done)
    else $error("done pulse too long");
  a_done_apart: assert property (!(pres_done && temp_done)) else $error("both done at once");
  a_temp_first: assert property (pres_done |-> seen_ff) else $error("pressure before temperature");
  a_oneshot_stops: assert property ((pres_done || temp_done) && stby_ff[3:0] == 4'h1
    |-> ##[0:2] !start_bit) else $error("one-shot left start set");
  a_temp_average: assert property (temp_done |=> avg_samples == (8'h01 << avg_ff[2:0]))
    else $error("temperature average count wrong");
  a_pres_average: assert property (pres_done |=> avg_samples == (8'h01 << avg_ff[5:3]))
    else $error("pressure average count wrong");
  a_idle_silent: assert property (!start_bit && !meas_busy |=> !pres_done && !temp_done)
    else $error("result while idle");
  cover property (temp_done ##[1:400] pres_done);
  cover property (pres_done && stby_ff[3:0] == 4'h0);
  cover property (pres_done && stby_ff[3:0] == 4'h2);
  cover property (start_wr && !start_wdata && meas_busy);
endmodule : msch_checker

bind msch_scheduler msch_checker chk_u (.clock, .srst, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .start_wr,
  .start_wdata, .start_bit, .meas_busy, .pres_done, .temp_done, .avg_samples);

//--- verification/msch_scheduler_tb_top.sv
`timescale 1ns/100ps
// ****************************
// register driven scenarios
// ****************************
module msch_scheduler_tb_top;
  logic clock = 0, srst = 1, reg_wr = 0, start_wr = 0, start_wdata = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, avg_samples, kind, avg_seen;
  logic start_bit, meas_busy, pres_done, temp_done;
  logic [7:0] exp_kind [6] = '{8'h01, 8'h02, 8'h02, 8'h02, 8'h02, 8'h01};
  int failures = 0, comparisons = 0, cycles = 0, gap;
  // one millisecond is four clocks here to keep the run short
  msch_scheduler #(.TICK_CYCLES(4), .TEMP_CONV_MS(1)) dut_u (.clock, .srst, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rdata, .start_wr, .start_wdata, .start_bit, .meas_busy, .pres_done, .temp_done, .avg_samples);
  initial forever #2 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp8
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clock); reg_wr <= 1'b0;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    reg_addr <= a;
    repeat (2) @(posedge clock);
    #1 cmp8(what, exp, reg_rdata);
    @(posedge clock);
  endtask : rd
  task automatic start(input logic v);
    start_wdata <= v; start_wr <= 1'b1;
    @(posedge clock); start_wr <= 1'b0;
    @(posedge clock);
  endtask : start
  // waits for a result pulse, bounded; avg count sampled one clock later
  task automatic wait_done();
    gap = 0;
    do begin
      @(posedge clock); #1 gap++;
    end while (pres_done !== 1'b1 && temp_done !== 1'b1 && gap < 3000);
    kind = {6'h00, pres_done, temp_done};
    @(posedge clock); #1 avg_seen = avg_samples;
    @(posedge clock);
  endtask : wait_done
  task automatic report_and_stop();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rd(8'h07, 8'h08, "measurement_config");
    rd(8'h08, 8'h00, "standby_config");
    rd(8'h09, 8'h00, "averaging_config");
    rd(8'h0A, 8'h00, "unmapped");
    $display("test reset_values done");
    wr(8'h07, 8'h09);
    wr(8'h08, 8'h01);
    wr(8'h09, 8'h19);
    rd(8'h07, 8'h09, "measurement_config");
    rd(8'h08, 8'h01, "standby_config");
    rd(8'h09, 8'h19, "averaging_config");
    $display("test readback done");
    start(1'b1);
    wait_done();
    cmp8("one-shot kind", 8'h01, kind);
    cmp8("temp average", 8'h02, avg_seen);
    repeat (3) @(posedge clock);
    #1 cmp8("start after one-shot", 8'h00, {6'h00, start_bit, meas_busy});
    @(posedge clock);
    $display("test one_shot done");
    wr(8'h08, 8'h00);
    start(1'b1);
    for (int i = 0; i < 6; i++) begin
      wait_done();
      cmp8("result kind", exp_kind[i], kind);
      if (kind == 8'h02) cmp8("pressure average", 8'h08, avg_seen);
      // first pressure: 8 ms then seven 2 ms samples; later ones: 8 samples of 2 ms
      if (i == 1) cmp8("first pressure interval", 8'h01, {7'h00, (gap + 2) inside {[84:92]}});
      if (i == 3) cmp8("pressure interval", 8'h01, {7'h00, (gap + 2) inside {[58:70]}});
    end
    start(1'b0);
    repeat (3) @(posedge clock);
    #1 cmp8("stopped", 8'h00, {6'h00, start_bit, meas_busy});
    @(posedge clock);
    $display("test continuous done");
    wr(8'h08, 8'h02);
    start(1'b1);
    wait_done();
    cmp8("paced first kind", 8'h01, kind);
    wait_done();
    cmp8("paced second kind", 8'h02, kind);
    cmp8("paced pressure average", 8'h08, avg_seen);
    // 10 ms pause, then 8 ms plus seven 2 ms samples, four clocks per ms
    cmp8("paced interval", 8'h01, {7'h00, (gap + 2) inside {[124:132]}});
    start(1'b0);
    repeat (3) @(posedge clock);
    #1 cmp8("paced stopped", 8'h00, {6'h00, start_bit, meas_busy});
    @(posedge clock);
    $display("test paced done");
    report_and_stop();
  end
endmodule : msch_scheduler_tb_top
